// ### rtl/sfec_pkg.sv
// sfec_pkg: opcodes, frame lengths, sector geometry and timing for the erase controller
// assumes a 10 MHz system clock sampling a slow serial link
`default_nettype none
package sfec_pkg;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;     // write_enable_cmd
  localparam logic [7:0] OP_PSE3 = 8'h20;     // param_sector_erase, address per extended mode
  localparam logic [7:0] OP_PSE4 = 8'h21;     // param_sector_erase, 4-byte address
  localparam logic [7:0] OP_SE3 = 8'hd8;      // sector_erase, address per extended mode
  localparam logic [7:0] OP_SE4 = 8'hdc;      // sector_erase, 4-byte address
  localparam logic [7:0] OP_BE1 = 8'h60;      // bulk_erase
  localparam logic [7:0] OP_BE2 = 8'hc7;      // bulk_erase
  localparam logic [7:0] OP_ESUS = 8'h75;     // erase_suspend_cmd
  localparam logic [7:0] OP_ERES = 8'h7a;     // erase_resume_cmd
  localparam logic [7:0] OP_PROGRAM_SUSPEND_CMD = 8'h85;     // program_suspend_cmd
  localparam logic [7:0] OP_PP3 = 8'h02;      // page program
  localparam logic [7:0] OP_PP4 = 8'h12;      // page program, 4-byte address
  localparam logic [7:0] OP_WRR = 8'h01;      // status_config_write_cmd
  localparam logic [7:0] OP_BANK_REGISTER_ACCESS_CMD = 8'hb9;     // bank_register_access_cmd
  localparam logic [7:0] OP_PPBE = 8'he4;     // persistent protect erase
  localparam logic [5:0] BITS_OP = 6'd8;      // instruction length
  localparam logic [5:0] BITS_A3 = 6'd32;     // instruction plus 24 address bits
  localparam logic [5:0] BITS_A4 = 6'd40;     // instruction plus 32 address bits
  localparam int SEC64_LSB = 16;              // 64 kB sector index position
  localparam int SEC256_LSB = 18;             // 256 kB sector index position
  localparam int SUB4_LSB = 12;               // 4 kB sub-sector field
  localparam logic [7:0] PARAM_TOP = 8'h01;   // 64 kB sectors holding 4 kB parameter sectors
  localparam int CLK_HZ = 10000000;
  localparam int ESL_NS = 2000;               // suspend latency, longest
  localparam int ESL_CYC = (ESL_NS * (CLK_HZ / 1000000)) / 1000;
  typedef enum logic [4:0] {
    SFEC_IDLE = 5'b00001,
    SFEC_ERASE = 5'b00010,
    SFEC_SUSPENDING = 5'b00100,
    SFEC_SUSPENDED = 5'b01000,
    SFEC_PROGRAM = 5'b10000
  } sfec_state_t;
endpackage : sfec_pkg
`default_nettype wire

// ### rtl/sfec_link_rx.sv
// sfec_link_rx: synchronises serial link pins and shifts in command frames
// assumes link clock well below the system clock; mode 0 sampling on rising edges
`default_nettype none
module sfec_link_rx
  import sfec_pkg::*;
(
  input wire logic mclk,              // system clock
  input wire logic sys_rst,           // synchronous reset
  input wire logic linkClk,           // serial clock pin
  input wire logic chipSelN,          // chip select pin, low active
  input wire logic serialIn,          // serial data pin
  output logic [39:0] frameBits,      // shifted bits, newest in bit 0
  output logic [5:0] frameCount,      // bits taken this frame
  output logic frameEnd               // pulse when chip select rises
);
  logic [2:0] sckSync_reg;
  logic [2:0] csSync_reg;
  logic [1:0] siSync_reg;
  logic [39:0] shift_reg;
  logic [5:0] count_reg;
  logic frameEnd_reg;
  wire sckRise = sckSync_reg[1] & ~sckSync_reg[2];
  wire csLow = ~csSync_reg[1];
  wire csRise = csSync_reg[1] & ~csSync_reg[2];
  // stops one past the longest frame so an over-long frame never decodes as 40 bits
  wire countMax = (count_reg == BITS_A4 + 6'h1);

  // two-stage synchronisers, the third stage only for edge finding
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sckSync_reg <= 3'h0;
      csSync_reg <= 3'h7;
      siSync_reg <= 2'h0;
    end
    else
    begin
      sckSync_reg <= {sckSync_reg[1:0], linkClk};
      csSync_reg <= {csSync_reg[1:0], chipSelN};
      siSync_reg <= {siSync_reg[0], serialIn};
    end
  end

  // shift bits while selected; count saturates past the longest frame
  always_ff @(posedge mclk)
  begin
    if (sys_rst || csRise)
    begin
      count_reg <= 6'h0;
      shift_reg <= sys_rst ? 40'h0 : shift_reg;
    end
    else if (csLow && sckRise)
    begin
      shift_reg <= {shift_reg[38:0], siSync_reg[1]};
      count_reg <= countMax ? count_reg : count_reg + 6'h1;
    end
  end

  // frame snapshot taken as chip select rises
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      frameBits <= 40'h0;
      frameCount <= 6'h0;
      frameEnd_reg <= 1'b0;
    end
    else
    begin
      frameEnd_reg <= csRise;
      if (csRise)
      begin
        frameBits <= shift_reg;
        frameCount <= count_reg;
      end
    end
  end
  assign frameEnd = frameEnd_reg;
endmodule : sfec_link_rx
`default_nettype wire

// ### rtl/sfec_erase_ctrl.sv
// sfec_erase_ctrl: erase command decode, protection checks and suspend/resume sequencing
// assumes an array engine that runs an erase given start/halt/continue pulses
`default_nettype none
//
// Contract
// - parameter sector erase ignored when the 256 kB uniform option is set.
// - parameter sector erase needs the write enable latch set first.
// - 20h takes 3 or 4 address bytes by mode; 21h always four.
// - sector-type erase starts only if chip select rises right after address.
// - write in progress reads 1 while erasing, 0 when done.
// - protected parameter sector erase not run; erase error set.
// - parameter erase into a large sector dropped silently, no error.
// - D8h address by mode, DCh four bytes; needs write enable.
// - protected sector erase not run; erase error set.
// - sector erase size is 64 kB or 256 kB by option.
// - range containing a protected sub-range refused with erase error.
// - bulk erase 60h or C7h starts only if chip select rises after opcode.
// - bulk erase only with block protect bits zero; else dropped, no error.
// - bulk erase skips per-sector protected sectors without error.
// - erase suspend acts only during sector erase, not bulk erase.
// - suspend halts erase and updates status within bounded latency.
// - on suspend write in progress drops; suspended flag shows suspension.
// - resume only when suspended; sets write in progress, continues.
// - reads inside the suspended sector flagged undefined; others valid.
// - while suspended reject status writes, except bank write after bank access.
// - program to suspended sector fails with program error; back to suspended.
// - program suspend accepted while erase suspended.
module sfec_erase_ctrl
  import sfec_pkg::*;
(
  input wire logic mclk,              // system clock
  input wire logic sys_rst,           // synchronous reset
  input wire logic linkClk,           // serial clock pin
  input wire logic chipSelN,          // chip select pin, low active
  input wire logic serialIn,          // serial data pin
  input wire logic extendedAddressing, // 4-byte address mode
  input wire logic uniform256,        // 256 kB sector option
  input wire logic [2:0] blockProtect, // block protect bits 2..0
  input wire logic bpRangeHit,        // block protection covers the target
  input wire logic [15:0] sectorProtect, // per-4kB protect in target 64 kB
  input wire logic [3:0] rangeProtect, // per-64kB protect in target 256 kB
  input wire logic readActive,        // array read in progress
  input wire logic [31:0] readAddr,   // array read address
  input wire logic engineDone,        // array engine finished
  input wire logic progDone,          // program operation finished
  output logic [31:0] addrOut,        // target address to engine and checks
  output logic eraseStart,            // pulse: start erase
  output logic [1:0] eraseKind,       // 0 param, 1 sector, 2 bulk
  output logic skipProtected,         // bulk: skip per-sector protected
  output logic eraseHalt,             // pulse: suspend engine
  output logic eraseContinue,         // pulse: resume engine
  output logic progStart,             // pulse: program allowed
  output logic progSuspend,           // pulse: nested program suspend
  output logic bankWrite,             // pulse: bank address register write
  output logic statusWrite,           // pulse: status/config write allowed
  output logic ppbErase,              // pulse: persistent protect erase allowed
  output logic writeInProgress,       // status bit 0 of first status reg
  output logic eraseSuspended,        // status bit 1 of second status reg
  output logic writeEnableLatch,      // write enable latch
  output logic eraseError,            // erase error flag
  output logic programError,          // program error flag
  output logic readUndefined          // read hits the suspended sector
);
  // ---------------------------------------------------------------
  // link receive
  // ---------------------------------------------------------------
  logic [39:0] frameBits;
  logic [5:0] frameCount;
  logic frameEnd;
  sfec_link_rx u_rx (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .linkClk(linkClk),
    .chipSelN(chipSelN),
    .serialIn(serialIn),
    .frameBits(frameBits),
    .frameCount(frameCount),
    .frameEnd(frameEnd)
  );

  // ---------------------------------------------------------------
  // frame decode
  // ---------------------------------------------------------------
  sfec_state_t state_reg, state_next;
  logic [31:0] addr_reg;
  logic [31:0] suspAddr_reg;
  logic [15:0] latency_reg;
  logic kindBulk_reg;
  logic bank_register_access_cmd_reg;
  wire [7:0] op3 = frameBits[31:24];
  wire [7:0] op4 = frameBits[39:32];
  wire [7:0] op1 = frameBits[7:0];
  wire [31:0] a3 = {8'h0, frameBits[23:0]};
  wire [31:0] a4 = frameBits[31:0];
  wire len1 = (frameCount == BITS_OP);
  wire len3 = (frameCount == BITS_A3) && !extendedAddressing;
  wire lenExt = (frameCount == BITS_A4) && extendedAddressing;
  wire len4 = (frameCount == BITS_A4);
  // frame lengths per opcode, WRR taking any length over 8 bits; any other length discards the command
  wire isPse = frameEnd && ((len3 && op3 == OP_PSE3) || (lenExt && op4 == OP_PSE3)
    || (len4 && op4 == OP_PSE4));
  wire isSe = frameEnd && ((len3 && op3 == OP_SE3) || (lenExt && op4 == OP_SE3)
    || (len4 && op4 == OP_SE4));
  wire [31:0] tgt = len3 ? a3 : a4;
  wire isBe = frameEnd && len1 && (op1 == OP_BE1 || op1 == OP_BE2);
  wire isPp = frameEnd && ((len3 && op3 == OP_PP3) || (lenExt && op4 == OP_PP3)
    || (len4 && op4 == OP_PP4));
  wire isWren = frameEnd && len1 && op1 == OP_WRITE_ENABLE_CMD;
  wire isSusp = frameEnd && len1 && op1 == OP_ESUS;
  wire isRes = frameEnd && len1 && op1 == OP_ERES;
  wire isPgsp = frameEnd && len1 && op1 == OP_PROGRAM_SUSPEND_CMD;
  wire isBrac = frameEnd && len1 && op1 == OP_BANK_REGISTER_ACCESS_CMD;
  wire isWrr = frameEnd && frameCount > BITS_OP && frameBits[15:8] == OP_WRR;
  wire isPpbe = frameEnd && len1 && op1 == OP_PPBE;

  // ---------------------------------------------------------------
  // protection checks
  // ---------------------------------------------------------------
  wire [7:0] sec64 = tgt[SEC64_LSB +: 8];
  wire inParam = (sec64 <= PARAM_TOP);
  wire [3:0] sub4 = tgt[SUB4_LSB +: 4];
  wire idle = (state_reg == SFEC_IDLE);
  wire write_enable_latch = writeEnableLatch;
  // parameter erase: option, latch, location, then protection
  wire pseTake = isPse && idle && write_enable_latch && !uniform256 && inParam;
  wire pseProt = bpRangeHit || sectorProtect[sub4];
  wire seProt = bpRangeHit || (uniform256 ? |rangeProtect : |sectorProtect);
  wire seTake = isSe && idle && write_enable_latch;
  wire beTake = isBe && idle && write_enable_latch && (blockProtect == 3'h0);
  wire pseGo = pseTake && !pseProt;
  wire seGo = seTake && !seProt;
  wire errSet = (pseTake && pseProt) || (seTake && seProt);
  wire suspOk = isSusp && state_reg == SFEC_ERASE && !kindBulk_reg;
  wire resOk = isRes && state_reg == SFEC_SUSPENDED;
  wire latDone = (latency_reg == 16'(ESL_CYC));
  wire suspSec = uniform256
    ? (tgt[31:SEC256_LSB] == suspAddr_reg[31:SEC256_LSB])
    : (tgt[31:SEC64_LSB] == suspAddr_reg[31:SEC64_LSB]);
  wire pgmOk = isPp && state_reg == SFEC_SUSPENDED && write_enable_latch && !suspSec;
  wire pgmBad = isPp && state_reg == SFEC_SUSPENDED && write_enable_latch && suspSec;
  wire rdSec = uniform256
    ? (readAddr[31:SEC256_LSB] == suspAddr_reg[31:SEC256_LSB])
    : (readAddr[31:SEC64_LSB] == suspAddr_reg[31:SEC64_LSB]);
  wire suspHeld = (state_reg == SFEC_SUSPENDED) || (state_reg == SFEC_PROGRAM);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      SFEC_IDLE:
        if (pseGo || seGo || beTake)
          state_next = SFEC_ERASE;
      SFEC_ERASE:
        if (engineDone)
          state_next = SFEC_IDLE;
        else if (suspOk)
          state_next = SFEC_SUSPENDING;
      SFEC_SUSPENDING:
        if (engineDone)
          state_next = SFEC_IDLE; // completed before halting
        else if (latDone)
          state_next = SFEC_SUSPENDED;
      SFEC_SUSPENDED:
        if (resOk)
          state_next = SFEC_ERASE;
        else if (pgmOk)
          state_next = SFEC_PROGRAM;
      SFEC_PROGRAM:
        if (progDone)
          state_next = SFEC_SUSPENDED;
      default:
        state_next = SFEC_IDLE;
    endcase
  end

  // state, target and latency counter
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_reg <= SFEC_IDLE;
      addr_reg <= 32'h0;
      suspAddr_reg <= 32'h0;
      latency_reg <= 16'h0;
      kindBulk_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      latency_reg <= (state_reg == SFEC_SUSPENDING) ? latency_reg + 16'h1 : 16'h0;
      if (pseGo || seGo || beTake)
      begin
        kindBulk_reg <= beTake;
        suspAddr_reg <= tgt;
      end
      if (frameEnd && frameCount >= BITS_A3)
        addr_reg <= tgt;
    end
  end

  // write enable latch, bank access marker, error flags
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      writeEnableLatch <= 1'b0;
      bank_register_access_cmd_reg <= 1'b0;
      eraseError <= 1'b0;
      programError <= 1'b0;
    end
    else
    begin
      if (isWren)
        writeEnableLatch <= 1'b1;
      else if (pseTake || seTake || beTake || pgmOk || pgmBad)
        writeEnableLatch <= 1'b0;
      if (frameEnd)
        bank_register_access_cmd_reg <= isBrac;
      if (errSet)
        eraseError <= 1'b1;
      if (pgmBad)
        programError <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign addrOut = addr_reg;
  assign eraseStart = pseGo || seGo || beTake;
  assign eraseKind = beTake ? 2'h2 : (seGo ? 2'h1 : 2'h0);
  assign skipProtected = kindBulk_reg;
  assign eraseHalt = suspOk;
  assign eraseContinue = resOk;
  assign progStart = pgmOk;
  assign progSuspend = isPgsp && state_reg == SFEC_PROGRAM;
  assign bankWrite = isWrr && bank_register_access_cmd_reg;
  assign statusWrite = isWrr && !bank_register_access_cmd_reg && !suspHeld && write_enable_latch;
  assign ppbErase = isPpbe && !suspHeld && write_enable_latch;
  // in progress during erase, the suspend latency and a nested program; clear while halted with no program
  assign writeInProgress = (state_reg == SFEC_ERASE) || (state_reg == SFEC_SUSPENDING)
    || (state_reg == SFEC_PROGRAM);
  assign eraseSuspended = suspHeld;
  assign readUndefined = readActive && suspHeld && rdSec;
endmodule : sfec_erase_ctrl
`default_nettype wire

// ### verif/sfec_erase_ctrl_assertions.sv
// sfec_erase_ctrl_assertions: port-level checks of the erase controller
// assumes binding into sfec_erase_ctrl, one clock domain with synchronous reset
`default_nettype none
module sfec_erase_ctrl_assertions
(
  input wire logic mclk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic uniform256, // 256 kB sector option
  input wire logic [2:0] blockProtect, // block protect bits
  input wire logic readActive, // array read in progress
  input wire logic eraseStart, // erase accepted pulse
  input wire logic [1:0] eraseKind, // kind of erase
  input wire logic skipProtected, // last erase started was bulk
  input wire logic eraseHalt, // suspend accepted pulse
  input wire logic eraseContinue, // resume accepted pulse
  input wire logic statusWrite, // status write pulse
  input wire logic progStart, // program allowed pulse
  input wire logic progSuspend, // nested program suspend pulse
  input wire logic ppbErase, // persistent protect erase pulse
  input wire logic writeInProgress, // busy status bit
  input wire logic eraseSuspended, // suspended status bit
  input wire logic writeEnableLatch, // write enable latch
  input wire logic readUndefined // read hits suspended sector
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  chk_start_needs_wel: assert property (eraseStart |-> writeEnableLatch)
    else $error("erase started without write enable");
  chk_start_sets_wip: assert property (eraseStart |=> writeInProgress && !writeEnableLatch)
    else $error("busy not set or latch kept after start");
  chk_param_uniform: assert property (eraseStart && eraseKind == 2'h0 |-> !uniform256)
    else $error("parameter erase ran with 256 kB option");
  chk_bulk_needs_bp: assert property (eraseStart && eraseKind == 2'h2 |-> blockProtect == 3'h0)
    else $error("bulk erase ran with protect bits set");
  chk_bulk_skips: assert property (eraseStart && eraseKind == 2'h2 |=> skipProtected)
    else $error("bulk erase without protected skip");
  chk_halt_not_bulk: assert property (eraseHalt |-> !skipProtected && writeInProgress)
    else $error("suspend accepted outside sector erase");
  chk_suspend_bound: assert property (eraseHalt |=> writeInProgress [*8] ##[1:20] !writeInProgress)
    else $error("suspend latency out of bounds");
  chk_suspend_flag: assert property ($rose(eraseSuspended) |-> !writeInProgress && $past(writeInProgress))
    else $error("suspended flag without busy drop");
  chk_resume_only: assert property (eraseContinue |-> eraseSuspended ##1 (writeInProgress && !eraseSuspended))
    else $error("resume outside suspend or status wrong");
  chk_no_status_susp: assert property (statusWrite |-> !eraseSuspended)
    else $error("status write taken while suspended");
  chk_undef_cause: assert property (readUndefined |-> readActive && eraseSuspended)
    else $error("undefined read flagged without suspend");
  chk_prog_in_susp: assert property (progStart |-> eraseSuspended && !writeInProgress)
    else $error("program allowed outside erase suspend");
  chk_program_suspend_cmd_nested: assert property (progSuspend |-> eraseSuspended && writeInProgress)
    else $error("program suspend outside nested program");
  chk_ppbe_susp: assert property (ppbErase |-> !eraseSuspended)
    else $error("protect erase taken while suspended");
endmodule : sfec_erase_ctrl_assertions
bind sfec_erase_ctrl sfec_erase_ctrl_assertions chk (.mclk, .sys_rst, .uniform256, .blockProtect,
  .readActive, .eraseStart, .eraseKind, .skipProtected, .eraseHalt, .eraseContinue, .statusWrite,
  .progStart, .progSuspend, .ppbErase,
  .writeInProgress, .eraseSuspended, .writeEnableLatch, .readUndefined);
`default_nettype wire

// ### verif/sfec_host_model.sv
// sfec_host_model: serial host that sends command frames in mode 0
// assumes mclk paces the link; one link bit takes 8 mclk cycles (800 ns)
`default_nettype none
module sfec_host_model
(
  input wire logic mclk, // system clock pacing the link
  output logic linkClk, // serial clock, still outside frames
  output logic chipSelN, // chip select, low active
  output logic serialIn // serial data
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle levels at time zero
  initial
  begin
    linkClk = 1'b0;
    chipSelN = 1'b1;
    serialIn = 1'b0;
  end
  // ----------------------------------------
  // frame sender
  // ----------------------------------------
  // msb first, data moves while the clock is low; released data shows the inverse
  task automatic send(input logic [39:0] bits, input int n);
    int i;
    @(posedge mclk);
    chipSelN <= 1'b0;
    for (i = n - 1; i >= 0; i--)
    begin
      serialIn <= bits[i];
      repeat (4) @(posedge mclk);
      linkClk <= 1'b1;
      repeat (4) @(posedge mclk);
      linkClk <= 1'b0;
    end
    repeat (4) @(posedge mclk);
    chipSelN <= 1'b1;
    serialIn <= ~serialIn;
    repeat (10) @(posedge mclk);
  endtask : send
endmodule : sfec_host_model
`default_nettype wire

// ### verif/serial_flash_erase_control_test.sv
// serial_flash_erase_control_test: self-checking bench for the erase controller
// assumes the host model drives the link pins and the bench plays the array engine
`default_nettype none
module serial_flash_erase_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sfec_pkg::*;
  logic mclk, sys_rst, extendedAddressing, uniform256, bpRangeHit, readActive;
  logic engineDone, progDone;
  logic [15:0] sectorProtect;
  wire logic programError, bankWrite, statusWrite;
  int bankCount = 0;
  int statusCount = 0;
  logic [2:0] blockProtect;
  logic [31:0] readAddr;
  wire logic linkClk, chipSelN, serialIn, writeInProgress, eraseSuspended;
  wire logic writeEnableLatch, eraseError, readUndefined;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  sfec_host_model h (.mclk, .linkClk, .chipSelN, .serialIn);
  sfec_erase_ctrl dut (.mclk, .sys_rst, .linkClk, .chipSelN, .serialIn, .extendedAddressing,
    .uniform256, .blockProtect, .bpRangeHit, .sectorProtect, .rangeProtect(4'h0),
    .readActive, .readAddr, .engineDone, .progDone, .addrOut(), .eraseStart(),
    .eraseKind(), .skipProtected(), .eraseHalt(), .eraseContinue(), .progStart(),
    .progSuspend(), .bankWrite, .statusWrite, .ppbErase(), .writeInProgress,
    .eraseSuspended, .writeEnableLatch, .eraseError, .programError, .readUndefined);
  // count one-cycle register write pulses
  always @(posedge mclk)
  begin
    if (bankWrite === 1'b1)
      bankCount++;
    if (statusWrite === 1'b1)
      statusCount++;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // clock and hang guard
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic write_enable_cmd();
    h.send({32'h0, OP_WRITE_ENABLE_CMD}, 8);
  endtask : write_enable_cmd
  // array engine reports completion
  task automatic done();
    @(posedge mclk);
    engineDone <= 1'b1;
    @(posedge mclk);
    engineDone <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : done
  task automatic finish_test();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_refused();
    h.send({8'h0, OP_SE3, 24'h030000}, 32);
    chk(writeInProgress, 1'b0);
    write_enable_cmd();
    chk(writeEnableLatch, 1'b1);
    h.send({7'h0, OP_SE3, 24'h030000, 1'b0}, 33);
    chk(writeInProgress, 1'b0);
    $display("test refused done");
  endtask : t_refused
  task automatic t_sector();
    int nStat;
    int nBank;
    write_enable_cmd();
    h.send({8'h0, OP_SE3, 24'h050000}, 32);
    chk(writeInProgress, 1'b1);
    chk(writeEnableLatch, 1'b0);
    h.send({32'h0, OP_ESUS}, 8);
    repeat (30) @(posedge mclk);
    chk(writeInProgress, 1'b0);
    chk(eraseSuspended, 1'b1);
    readActive <= 1'b1;
    readAddr <= 32'h0005_8000;
    repeat (2) @(posedge mclk);
    chk(readUndefined, 1'b1);
    readAddr <= 32'h0006_0000;
    repeat (2) @(posedge mclk);
    chk(readUndefined, 1'b0);
    readActive <= 1'b0;
    write_enable_cmd();
    h.send({8'h0, OP_PP3, 24'h050100}, 32);
    chk(programError, 1'b1);
    write_enable_cmd();
    h.send({8'h0, OP_PP3, 24'h060000}, 32);
    chk(writeInProgress, 1'b1);
    h.send({32'h0, OP_PROGRAM_SUSPEND_CMD}, 8);
    progDone <= 1'b1;
    @(posedge mclk);
    progDone <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(writeInProgress, 1'b0);
    chk(eraseSuspended, 1'b1);
    write_enable_cmd();
    nStat = statusCount;
    h.send({24'h0, OP_WRR, 8'h00}, 16);
    chk(statusCount == nStat, 1'b1);
    nBank = bankCount;
    h.send({32'h0, OP_BANK_REGISTER_ACCESS_CMD}, 8);
    h.send({24'h0, OP_WRR, 8'h00}, 16);
    chk(bankCount == nBank + 1, 1'b1);
    h.send({32'h0, OP_ERES}, 8);
    chk(writeInProgress, 1'b1);
    chk(eraseSuspended, 1'b0);
    h.send({32'h0, OP_ERES}, 8);
    chk(writeInProgress, 1'b1);
    done();
    chk(writeInProgress, 1'b0);
    $display("test sector done");
  endtask : t_sector
  task automatic t_param();
    uniform256 <= 1'b1;
    write_enable_cmd();
    h.send({OP_PSE4, 32'h0000_1000}, 40);
    chk(writeInProgress, 1'b0);
    uniform256 <= 1'b0;
    write_enable_cmd();
    h.send({OP_PSE4, 32'h0000_1000}, 40);
    chk(writeInProgress, 1'b1);
    done();
    extendedAddressing <= 1'b1;
    write_enable_cmd();
    h.send({OP_PSE3, 32'h0000_2000}, 40);
    chk(writeInProgress, 1'b1);
    done();
    extendedAddressing <= 1'b0;
    write_enable_cmd();
    h.send({8'h0, OP_PSE3, 24'h100000}, 32);
    chk(writeInProgress, 1'b0);
    chk(eraseError, 1'b0);
    $display("test param done");
  endtask : t_param
  task automatic t_bulk();
    blockProtect <= 3'h4;
    write_enable_cmd();
    h.send({32'h0, OP_BE1}, 8);
    chk(writeInProgress, 1'b0);
    chk(eraseError, 1'b0);
    blockProtect <= 3'h0;
    write_enable_cmd();
    h.send({24'h0, OP_BE1, 8'h00}, 16);
    chk(writeInProgress, 1'b0);
    h.send({32'h0, OP_BE2}, 8);
    chk(writeInProgress, 1'b1);
    h.send({32'h0, OP_ESUS}, 8);
    repeat (30) @(posedge mclk);
    chk(writeInProgress, 1'b1);
    chk(eraseSuspended, 1'b0);
    done();
    chk(writeInProgress, 1'b0);
    $display("test bulk done");
  endtask : t_bulk
  task automatic t_protect();
    h.send({24'h0, OP_WRR, 8'h00}, 16);
    sectorProtect <= 16'h0010;
    write_enable_cmd();
    h.send({8'h0, OP_SE3, 24'h070000}, 32);
    chk(writeInProgress, 1'b0);
    chk(eraseError, 1'b1);
    sectorProtect <= 16'h0000;
    bpRangeHit <= 1'b1;
    write_enable_cmd();
    h.send({OP_SE4, 32'h0004_0000}, 40);
    chk(writeInProgress, 1'b0);
    chk(eraseError, 1'b1);
    bpRangeHit <= 1'b0;
    $display("test protect done");
  endtask : t_protect
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    extendedAddressing = 1'b0;
    uniform256 = 1'b0;
    bpRangeHit = 1'b0;
    readActive = 1'b0;
    engineDone = 1'b0;
    progDone = 1'b0;
    sectorProtect = 16'h0000;
    blockProtect = 3'h0;
    readAddr = 32'h0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    t_refused();
    t_sector();
    t_param();
    t_bulk();
    t_protect();
    finish_test();
  end
endmodule : serial_flash_erase_control_test
`default_nettype wire
